// [logic/gpib_pkg.sv]
// package: shared constants and types for the bus interface
package gpib_pkg;
    localparam logic [2:0] CMD_GROUP_LAG  = 3'h1;
    localparam logic [2:0] CMD_GROUP_TAG  = 3'h2;
    localparam logic [7:0] CMD_GTL        = 8'h01;
    localparam logic [7:0] CMD_SDC        = 8'h04;
    localparam logic [7:0] CMD_DCL        = 8'h14;
    localparam logic [7:0] CMD_SPE        = 8'h18;
    localparam logic [7:0] CMD_SPD        = 8'h19;
    localparam logic [7:0] CMD_UNL        = 8'h3F;
    localparam logic [7:0] CMD_UNT        = 8'h5F;
    localparam logic [4:0] DEFAULT_ADDR   = 5'h06;
    localparam int         FIFO_WIDTH     = 9;
    localparam int         FIFO_DEPTH     = 16;
    localparam int         SYNC_STAGES    = 2;
    localparam logic [7:0] RESET_STATUS   = 8'h00;

    typedef enum {
        SRC_IDLE,
        SRC_WAIT_RFD,
        SRC_DRIVE,
        SRC_WAIT_DAC,
        SRC_RELEASE
    } src_state_t;

    typedef enum {
        ACC_IDLE,
        ACC_READY,
        ACC_TAKE,
        ACC_WAIT_DROP
    } acc_state_t;
endpackage : gpib_pkg

// [logic/stream_if.sv]
// interface: valid/ready byte stream between the bus engine and its fifo
`timescale 1ns/100ps
interface stream_if #(
    parameter int WIDTH = 9
);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface : stream_if

// [logic/stream_fifo.sv]
// module: parameterised valid/ready fifo
`timescale 1ns/100ps
module stream_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    // ports
    stream_if.sink    fill,
    stream_if.source  drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;
    logic             out_valid_reg;
    logic             out_valid_next;
    logic             push;
    logic             pop;

    // the output register counts as a slot, so capacity is DEPTH words
    assign fill.ready  = ((count_reg + (AW+1)'(out_valid_reg))
                          != (AW+1)'(DEPTH));
    assign push        = fill.valid && fill.ready;
    assign pop         = (count_reg != '0) &&
                         (!out_valid_reg || drain.ready);
    assign drain.data  = out_reg;
    assign drain.valid = out_valid_reg;

    always_comb begin
        wr_next        = push ? wr_reg + 1'b1 : wr_reg;
        rd_next        = pop ? rd_reg + 1'b1 : rd_reg;
        count_next     = count_reg + (AW+1)'(push) - (AW+1)'(pop);
        out_next       = pop ? mem_reg[rd_reg] : out_reg;
        out_valid_next = pop ? 1'b1
                       : (drain.ready ? 1'b0 : out_valid_reg);
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_reg[wr_reg] <= fill.data;
        end
        if (!rst_n_in) begin
            wr_reg        <= '0;
            rd_reg        <= '0;
            count_reg     <= '0;
            out_reg       <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            wr_reg        <= wr_next;
            rd_reg        <= rd_next;
            count_reg     <= count_next;
            out_reg       <= out_next;
            out_valid_reg <= out_valid_next;
        end
    end
endmodule : stream_fifo

// [logic/gpib_device_interface.sv]
// module: instrument-side talker/listener bus interface
`timescale 1ns/100ps
module gpib_device_interface
    import gpib_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int KEY_COUNT  = 8
) (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    // bus pins, active low; oe low while this end drives
    input  wire logic [7:0]            dio_n_in,
    output logic [7:0]                 dio_n_out,
    output logic                       dio_oe_n_out,
    input  wire logic                  dav_n_in,
    output logic                       dav_n_out,
    output logic                       dav_oe_n_out,
    input  wire logic                  nrfd_n_in,
    output logic                       nrfd_n_out,
    output logic                       nrfd_oe_n_out,
    input  wire logic                  ndac_n_in,
    output logic                       ndac_n_out,
    output logic                       ndac_oe_n_out,
    input  wire logic                  eoi_n_in,
    output logic                       eoi_n_out,
    output logic                       eoi_oe_n_out,
    input  wire logic                  atn_n_in,
    input  wire logic                  ifc_n_in,
    input  wire logic                  ren_n_in,
    output logic                       srq_oe_n_out,
    // configuration
    input  wire logic [4:0]            bus_addr_in,
    // talker data from the instrument
    input  wire logic [DATA_WIDTH-1:0] tx_data_in,
    input  wire logic                  tx_end_in,
    input  wire logic                  tx_valid_in,
    output logic                       tx_ready_out,
    input  wire logic [7:0]            status_byte_in,
    // listener data to the instrument
    output logic [DATA_WIDTH-1:0]      rx_data_out,
    output logic                       rx_end_out,
    output logic                       rx_valid_out,
    input  wire logic                  rx_ready_in,
    // front panel
    input  wire logic [KEY_COUNT-1:0]  key_in,
    input  wire logic                  local_key_in,
    output logic [KEY_COUNT-1:0]       key_out,
    // state
    output logic                       remote_out,
    output logic                       talker_out,
    output logic                       listener_out,
    output logic                       device_clear_out
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage one feeds stage two only
    localparam int SW = 14;
    logic [SW-1:0] meta_reg;
    logic [SW-1:0] sync_reg;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= {dio_n_in, dav_n_in, nrfd_n_in, ndac_n_in,
                         eoi_n_in, atn_n_in, ifc_n_in};
            sync_reg <= meta_reg;
        end
    end
    logic [7:0] bus_byte;
    logic       dav, nrfd, ndac, eoi, atn, ifc;
    assign {bus_byte, dav, nrfd, ndac, eoi, atn, ifc} = ~sync_reg;

    // remote enable and panel keys: same two stages
    logic [KEY_COUNT+1:0] slow_meta_reg;
    logic [KEY_COUNT+1:0] slow_sync_reg;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            slow_meta_reg <= '0;
            slow_sync_reg <= '0;
        end else begin
            slow_meta_reg <= {~ren_n_in, local_key_in, key_in};
            slow_sync_reg <= slow_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data fifos: listener bytes out, talker bytes in
    stream_if #(.WIDTH(FIFO_WIDTH)) rx_fill ();
    stream_if #(.WIDTH(FIFO_WIDTH)) rx_drain ();
    stream_if #(.WIDTH(FIFO_WIDTH)) tx_fill ();
    stream_if #(.WIDTH(FIFO_WIDTH)) tx_drain ();

    stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .fill     (rx_fill),
        .drain    (rx_drain)
    );
    stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .fill     (tx_fill),
        .drain    (tx_drain)
    );

    assign tx_fill.data  = {tx_end_in, tx_data_in[7:0]};
    assign tx_fill.valid = tx_valid_in && tx_ready_out;
    assign rx_drain.ready = rx_ready_in;

    ////////////////////////////////////////////////////////////////////////
    // addressing, remote/local and clear
    logic       talk_reg,   talk_next;
    logic       listen_reg, listen_next;
    logic       spoll_reg,  spoll_next;
    logic       remote_reg, remote_next;
    logic       clear_reg,  clear_next;
    logic       cmd_take;
    logic [7:0] cmd;
    logic       my_la;
    logic       my_ta;

    assign cmd   = {1'b0, bus_byte[6:0]};
    assign my_la = (cmd[7:5] == CMD_GROUP_LAG) && (cmd[4:0] == bus_addr_in);
    assign my_ta = (cmd[7:5] == CMD_GROUP_TAG) && (cmd[4:0] == bus_addr_in);

    always_comb begin
        talk_next   = talk_reg;
        listen_next = listen_reg;
        spoll_next  = spoll_reg;
        remote_next = remote_reg;
        clear_next  = 1'b0;
        if (cmd_take) begin
            if (my_la) begin
                listen_next = 1'b1;
                talk_next   = 1'b0;
                if (slow_sync_reg[KEY_COUNT+1]) begin
                    remote_next = 1'b1;
                end
            end else if (cmd == CMD_UNL) begin
                listen_next = 1'b0;
            end
            if (my_ta) begin
                talk_next   = 1'b1;
                listen_next = 1'b0;
            end else if (cmd[7:5] == CMD_GROUP_TAG) begin
                talk_next = 1'b0;
            end
            if (cmd == CMD_SPE || cmd == CMD_SPD) begin
                spoll_next = (cmd == CMD_SPE);
            end
            if (cmd == CMD_DCL || (cmd == CMD_SDC && listen_reg)) begin
                clear_next = 1'b1;
            end
            if (cmd == CMD_GTL && listen_reg) begin
                remote_next = 1'b0;
            end
        end
        if (slow_sync_reg[KEY_COUNT] || !slow_sync_reg[KEY_COUNT+1]) begin
            remote_next = 1'b0;
        end
        if (ifc) begin
            talk_next   = 1'b0;
            listen_next = 1'b0;
            spoll_next  = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            talk_reg   <= 1'b0;
            listen_reg <= 1'b0;
            spoll_reg  <= 1'b0;
            remote_reg <= 1'b0;
            clear_reg  <= 1'b0;
        end else begin
            talk_reg   <= talk_next;
            listen_reg <= listen_next;
            spoll_reg  <= spoll_next;
            remote_reg <= remote_next;
            clear_reg  <= clear_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acceptor handshake: commands under attention, data when listening
    acc_state_t acc_reg, acc_next;
    logic       nrfd_drv_next, ndac_drv_next;
    logic       acc_active;
    assign acc_active = atn || (listen_reg && rx_fill.ready);
    assign rx_fill.data  = {eoi, bus_byte};
    assign rx_fill.valid = (acc_reg == ACC_TAKE) && !atn && listen_reg;
    assign cmd_take      = (acc_reg == ACC_TAKE) && atn;

    always_comb begin
        acc_next      = acc_reg;
        nrfd_drv_next = 1'b1;
        ndac_drv_next = 1'b1;
        case (acc_reg)
            ACC_IDLE: begin
                if (acc_active && !dav) begin
                    acc_next = ACC_READY;
                end
            end
            ACC_READY: begin
                nrfd_drv_next = 1'b0;
                if (!acc_active) begin
                    acc_next = ACC_IDLE;
                end else if (dav) begin
                    acc_next = ACC_TAKE;
                end
            end
            ACC_TAKE: begin
                acc_next = ACC_WAIT_DROP;
            end
            ACC_WAIT_DROP: begin
                ndac_drv_next = 1'b0;
                if (!dav) begin
                    acc_next = ACC_IDLE;
                end
            end
            default: acc_next = ACC_IDLE;
        endcase
        // outside attention an unaddressed unit keeps off the lines
        if (!atn && !listen_reg && acc_reg == ACC_IDLE) begin
            ndac_drv_next = 1'b0;
            nrfd_drv_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source handshake: talker data or the status byte under serial poll
    src_state_t src_reg, src_next;
    logic [7:0] dout_reg, dout_next;
    logic       eoi_drv_reg, eoi_drv_next;
    logic       may_talk;
    assign may_talk = talk_reg && !atn;
    assign tx_drain.ready = (src_reg == SRC_IDLE) && may_talk && !spoll_reg;

    always_comb begin
        src_next     = src_reg;
        dout_next    = dout_reg;
        eoi_drv_next = eoi_drv_reg;
        case (src_reg)
            SRC_IDLE: begin
                if (may_talk && spoll_reg) begin
                    dout_next    = status_byte_in & 8'hBF;
                    eoi_drv_next = 1'b0;
                    src_next     = SRC_WAIT_RFD;
                end else if (tx_drain.ready && tx_drain.valid) begin
                    dout_next    = tx_drain.data[7:0];
                    eoi_drv_next = tx_drain.data[8];
                    src_next     = SRC_WAIT_RFD;
                end
            end
            SRC_WAIT_RFD: begin
                if (!nrfd) begin
                    src_next = SRC_DRIVE;
                end
            end
            SRC_DRIVE: begin
                src_next = SRC_WAIT_DAC;
            end
            SRC_WAIT_DAC: begin
                if (!ndac) begin
                    src_next = SRC_RELEASE;
                end
            end
            SRC_RELEASE: begin
                eoi_drv_next = 1'b0;
                if (ndac || !talk_reg) begin
                    src_next = spoll_reg ? SRC_WAIT_RFD : SRC_IDLE;
                end
            end
            default: src_next = SRC_IDLE;
        endcase
        if (!may_talk) begin
            src_next     = SRC_IDLE;
            eoi_drv_next = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            acc_reg      <= ACC_IDLE;
            src_reg      <= SRC_IDLE;
            dout_reg     <= '0;
            eoi_drv_reg  <= 1'b0;
        end else begin
            acc_reg      <= acc_next;
            src_reg      <= src_next;
            dout_reg     <= dout_next;
            eoi_drv_reg  <= eoi_drv_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    logic                 src_on;
    assign src_on = (src_next != SRC_IDLE);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            dio_n_out        <= '1;
            dio_oe_n_out     <= 1'b1;
            dav_n_out        <= 1'b1;
            dav_oe_n_out     <= 1'b1;
            nrfd_n_out       <= 1'b0;
            nrfd_oe_n_out    <= 1'b0;
            ndac_n_out       <= 1'b0;
            ndac_oe_n_out    <= 1'b0;
            eoi_n_out        <= 1'b1;
            eoi_oe_n_out     <= 1'b1;
            srq_oe_n_out     <= 1'b1;
            tx_ready_out     <= 1'b0;
            rx_data_out      <= '0;
            rx_end_out       <= 1'b0;
            rx_valid_out     <= 1'b0;
            key_out          <= '0;
            remote_out       <= 1'b0;
            talker_out       <= 1'b0;
            listener_out     <= 1'b0;
            device_clear_out <= 1'b0;
        end else begin
            dio_n_out        <= ~dout_next;
            dio_oe_n_out     <= !src_on;
            dav_n_out        <= !(src_next == SRC_WAIT_DAC);
            dav_oe_n_out     <= !src_on;
            nrfd_n_out       <= !nrfd_drv_next;
            nrfd_oe_n_out    <= !nrfd_drv_next;
            ndac_n_out       <= !ndac_drv_next;
            ndac_oe_n_out    <= !ndac_drv_next;
            eoi_n_out        <= !eoi_drv_next;
            eoi_oe_n_out     <= !(eoi_drv_next && src_on);
            srq_oe_n_out     <= 1'b1;
            tx_ready_out     <= tx_fill.ready;
            rx_data_out      <= DATA_WIDTH'(rx_drain.data[7:0]);
            rx_end_out       <= rx_drain.data[8];
            rx_valid_out     <= rx_drain.valid;
            key_out          <= remote_next ? '0 : slow_sync_reg[KEY_COUNT-1:0];
            remote_out       <= remote_next;
            talker_out       <= talk_next;
            listener_out     <= listen_next;
            device_clear_out <= clear_next;
        end
    end
endmodule : gpib_device_interface

// [bench/gpib_device_interface_properties.sv]
// checker: handshake, role and panel properties of the device interface
`timescale 1ns/100ps
module gpib_device_interface_properties #(
    parameter int KEY_COUNT = 8
) (
    input wire logic                 clock_in,
    input wire logic                 rst_n_in,
    input wire logic                 dav_n_in,
    input wire logic                 nrfd_n_in,
    input wire logic                 ndac_n_in,
    input wire logic                 atn_n_in,
    input wire logic                 ren_n_in,
    input wire logic                 dio_oe_n_out,
    input wire logic                 dav_n_out,
    input wire logic                 dav_oe_n_out,
    input wire logic                 nrfd_oe_n_out,
    input wire logic                 ndac_oe_n_out,
    input wire logic                 srq_oe_n_out,
    input wire logic [KEY_COUNT-1:0] key_in,
    input wire logic [KEY_COUNT-1:0] key_out,
    input wire logic                 remote_out,
    input wire logic                 talker_out,
    input wire logic                 listener_out,
    input wire logic                 device_clear_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence dav_driven;
        !dav_oe_n_out && !dav_n_out;
    endsequence
    sequence keys_settled;
        (!remote_out && $stable(key_in)) [*4];
    endsequence
    ////////////////////////////////////////////////////////////
    AST_SRQ_IDLE: assert property (srq_oe_n_out)
        else $error("service request line driven");
    AST_DAV_HOLD: assert property (dav_driven ##0
        (!ndac_n_in && atn_n_in && talker_out) |=> dav_driven)
        else $error("data valid dropped before accept");
    AST_DAV_AFTER_RFD: assert property (
        $rose(!dav_oe_n_out && !dav_n_out) |-> $past(nrfd_n_in, 2))
        else $error("data valid raised without ready");
    AST_NDAC_RELEASE: assert property (
        dav_oe_n_out && $fell(dav_n_in) |-> ##[1:8] ndac_oe_n_out)
        else $error("byte not accepted in time");
    AST_NRFD_ON_ACCEPT: assert property (
        $rose(ndac_oe_n_out) && !dav_n_in |-> !nrfd_oe_n_out)
        else $error("ready shown while accepting");
    AST_CLEAR_PULSE: assert property (
        device_clear_out |=> !device_clear_out)
        else $error("clear pulse longer than a cycle");
    AST_ROLE_EXCL: assert property (!(talker_out && listener_out))
        else $error("talker and listener at once");
    AST_NO_SOURCE: assert property (!talker_out [*3]
        |-> dav_oe_n_out && dio_oe_n_out)
        else $error("bus driven while not talker");
    AST_KEY_MASK: assert property (
        remote_out && $past(remote_out) |-> key_out == '0)
        else $error("panel key passed in remote");
    AST_KEY_PASS: assert property (keys_settled |-> key_out == key_in)
        else $error("panel key lost in local");
    AST_REN_LOCAL: assert property (ren_n_in [*4] |-> !remote_out)
        else $error("remote held without enable");
endmodule : gpib_device_interface_properties

bind gpib_device_interface gpib_device_interface_properties #(
    .KEY_COUNT(KEY_COUNT)
) gpib_device_interface_properties_i (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .dav_n_in(dav_n_in),
    .nrfd_n_in(nrfd_n_in), .ndac_n_in(ndac_n_in), .atn_n_in(atn_n_in),
    .ren_n_in(ren_n_in), .dio_oe_n_out(dio_oe_n_out),
    .dav_n_out(dav_n_out), .dav_oe_n_out(dav_oe_n_out),
    .nrfd_oe_n_out(nrfd_oe_n_out), .ndac_oe_n_out(ndac_oe_n_out),
    .srq_oe_n_out(srq_oe_n_out), .key_in(key_in), .key_out(key_out),
    .remote_out(remote_out), .talker_out(talker_out),
    .listener_out(listener_out), .device_clear_out(device_clear_out)
);

// [bench/gpib_host_model.sv]
// partner: bus controller model sending commands and data, taking replies
`timescale 1ns/100ps
module gpib_host_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] dio_n_in,
    input  wire logic       dav_n_in,
    input  wire logic       nrfd_n_in,
    input  wire logic       ndac_n_in,
    input  wire logic       eoi_n_in,
    output logic      [7:0] dio_n_out,
    output logic            dav_n_out,
    output logic            nrfd_n_out,
    output logic            ndac_n_out,
    output logic            eoi_n_out,
    output logic            atn_n_out,
    output logic            ifc_n_out,
    output logic            ren_n_out
);
    // remote enable true from the start
    initial begin
        {dio_n_out, dav_n_out, nrfd_n_out, ndac_n_out} = {8'hFF, 3'h7};
        {eoi_n_out, atn_n_out, ifc_n_out, ren_n_out} = 4'hE;
    end

    // one byte as source; atn true marks a command byte
    task automatic put(input logic atn, input logic [7:0] b, input logic e);
        int n;
        atn_n_out = !atn;
        nrfd_n_out = 1'b1;
        ndac_n_out = 1'b1;
        repeat (4) @(posedge clock_in);
        for (n = 0; n < 300 && nrfd_n_in !== 1'b1; n++) @(posedge clock_in);
        // no ready listener: give up rather than strobe into nothing
        if (nrfd_n_in === 1'b1) begin
            @(negedge clock_in);
            dio_n_out = ~b;
            eoi_n_out = !e;
            @(negedge clock_in);
            dav_n_out = 1'b0;
            for (n = 0; n < 300 && ndac_n_in !== 1'b1; n++)
                @(posedge clock_in);
            @(negedge clock_in);
            {dav_n_out, eoi_n_out, dio_n_out} = {2'h3, 8'hFF};
        end
        @(negedge clock_in);
    endtask : put

    // one byte as acceptor; slow delays the accept
    task automatic get(output logic [7:0] b, output logic e, input int slow);
        int n;
        atn_n_out = 1'b1;
        ndac_n_out = 1'b0;
        nrfd_n_out = 1'b1;
        for (n = 0; n < 300 && dav_n_in !== 1'b0; n++) @(posedge clock_in);
        b = ~dio_n_in;
        e = !eoi_n_in;
        @(negedge clock_in);
        nrfd_n_out = 1'b0;
        repeat (slow) @(negedge clock_in);
        ndac_n_out = 1'b1;
        for (n = 0; n < 300 && dav_n_in !== 1'b1; n++) @(posedge clock_in);
        @(negedge clock_in);
        ndac_n_out = 1'b0;
    endtask : get
endmodule : gpib_host_model

// [bench/tb_gpib_device_interface.sv]
// testbench: device interface against the bus controller model
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("Error t=%0t got %h exp %h", $time, got, exp); \
    end \
end
module tb_gpib_device_interface
    import gpib_pkg::*;
;
    localparam logic [7:0] MLA = {CMD_GROUP_LAG, DEFAULT_ADDR};
    localparam logic [7:0] MTA = {CMD_GROUP_TAG, DEFAULT_ADDR};
    logic       clock_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [7:0] d_dio, h_dio, w_dio, key_o, rx_data;
    logic [7:0] tx_data = 8'h00, status = 8'h00, key = 8'h00;
    logic       d_dio_oe, d_dav, d_dav_oe, d_nrfd, d_nrfd_oe, d_ndac;
    logic       d_ndac_oe, d_eoi, d_eoi_oe, h_dav, h_nrfd, h_ndac, h_eoi;
    logic       w_dav, w_nrfd, w_ndac, w_eoi, atn_n, ifc_n, ren_n;
    logic       tx_end = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
    logic       local_key = 1'b0, tx_ready, rx_end, rx_valid;
    logic       srq_oe, remote, talker, listener, dclr;
    logic [8:0] rxq[$];
    int         fail_count = 0, comparisons = 0, clears = 0;

    // open-collector lines: low if any party pulls low
    assign w_dio = h_dio & (d_dio_oe ? 8'hFF : d_dio);
    assign w_dav = h_dav & (d_dav_oe | d_dav);
    assign w_nrfd = h_nrfd & (d_nrfd_oe | d_nrfd);
    assign w_ndac = h_ndac & (d_ndac_oe | d_ndac);
    assign w_eoi = h_eoi & (d_eoi_oe | d_eoi);
    always #50 clock_in = ~clock_in;
    always @(posedge clock_in) if (rx_valid && rx_ready)
        rxq.push_back({rx_end, rx_data});
    always @(posedge clock_in) if (dclr === 1'b1) clears++;

    gpib_device_interface gpib_device_interface_i (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .dio_n_in(w_dio),
        .dio_n_out(d_dio), .dio_oe_n_out(d_dio_oe), .dav_n_in(w_dav),
        .dav_n_out(d_dav), .dav_oe_n_out(d_dav_oe), .nrfd_n_in(w_nrfd),
        .nrfd_n_out(d_nrfd), .nrfd_oe_n_out(d_nrfd_oe), .ndac_n_in(w_ndac),
        .ndac_n_out(d_ndac), .ndac_oe_n_out(d_ndac_oe), .eoi_n_in(w_eoi),
        .eoi_n_out(d_eoi), .eoi_oe_n_out(d_eoi_oe), .atn_n_in(atn_n),
        .ifc_n_in(ifc_n), .ren_n_in(ren_n), .srq_oe_n_out(srq_oe),
        .bus_addr_in(DEFAULT_ADDR), .tx_data_in(tx_data), .tx_end_in(tx_end),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .status_byte_in(status), .rx_data_out(rx_data), .rx_end_out(rx_end),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .key_in(key),
        .local_key_in(local_key), .key_out(key_o), .remote_out(remote),
        .talker_out(talker), .listener_out(listener),
        .device_clear_out(dclr)
    );
    gpib_host_model gpib_host_model_i (
        .clock_in(clock_in), .dio_n_in(w_dio), .dav_n_in(w_dav),
        .nrfd_n_in(w_nrfd), .ndac_n_in(w_ndac), .eoi_n_in(w_eoi),
        .dio_n_out(h_dio), .dav_n_out(h_dav), .nrfd_n_out(h_nrfd),
        .ndac_n_out(h_ndac), .eoi_n_out(h_eoi), .atn_n_out(atn_n),
        .ifc_n_out(ifc_n), .ren_n_out(ren_n)
    );
    ////////////////////////////////////////////////////////////
    task automatic wcyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask : wcyc
    task automatic cmd(input logic [7:0] b);
        gpib_host_model_i.put(1'b1, b, 1'b0);
    endtask : cmd
    task automatic push(input logic [7:0] d, input logic e);
        {tx_data, tx_end, tx_valid} = {d, e, 1'b1};
        @(negedge clock_in);
        tx_valid = 1'b0;
        @(negedge clock_in);
    endtask : push

    task automatic t_listen;
        int n;
        cmd(CMD_UNL);
        gpib_host_model_i.put(1'b0, 8'hEE, 1'b0);
        wcyc(8);
        `CHK(rxq.size(), 0)
        cmd(MLA);
        wcyc(3);
        `CHK({listener, remote}, 2'h3)
        gpib_host_model_i.put(1'b0, 8'h3A, 1'b0);
        gpib_host_model_i.put(1'b0, 8'hC5, 1'b1);
        for (n = 0; n < 50 && rxq.size() < 2; n++) wcyc(1);
        `CHK(rxq[0], 9'h03A)
        `CHK(rxq[1], 9'h1C5)
    endtask : t_listen

    task automatic t_panel;
        key = 8'hA5;
        wcyc(5);
        `CHK(key_o, 8'h00)
        local_key = 1'b1;
        wcyc(2);
        local_key = 1'b0;
        wcyc(5);
        `CHK({remote, key_o}, 9'h0A5)
        cmd(MLA);
        wcyc(3);
        `CHK(remote, 1'b1)
        cmd(CMD_GTL);
        wcyc(3);
        `CHK(remote, 1'b0)
        cmd(MLA);
        gpib_host_model_i.ren_n_out = 1'b1;
        wcyc(6);
        `CHK(remote, 1'b0)
        gpib_host_model_i.ren_n_out = 1'b0;
    endtask : t_panel

    task automatic t_talk;
        int n;
        logic [7:0] b;
        logic e;
        // fill before talking so nothing drains
        for (n = 0; n < 40 && tx_ready === 1'b1; n++) push(n[7:0], n == 15);
        `CHK(n, FIFO_DEPTH)
        cmd(MTA);
        wcyc(3);
        `CHK({talker, listener}, 2'h2)
        for (n = 0; n < 16; n++) begin
            gpib_host_model_i.get(b, e, (n % 2) * 3);
            `CHK({e, b}, {n == 15, n[7:0]})
        end
        cmd(MLA);
        wcyc(3);
        `CHK({talker, listener}, 2'h1)
    endtask : t_talk

    task automatic t_poll;
        logic [7:0] b;
        logic e;
        status = 8'h5A;
        cmd(CMD_SPE);
        cmd(MTA);
        gpib_host_model_i.get(b, e, 0);
        `CHK(b, 8'h1A)
        cmd(CMD_SPD);
        cmd(CMD_UNT);
        wcyc(3);
        `CHK(talker, 1'b0)
    endtask : t_poll

    task automatic t_clear;
        cmd(CMD_DCL);
        wcyc(4);
        `CHK(clears, 1)
        cmd(MLA);
        cmd(CMD_SDC);
        wcyc(4);
        `CHK(clears, 2)
        cmd(CMD_UNL);
        cmd(CMD_SDC);
        wcyc(4);
        `CHK(clears, 2)
    endtask : t_clear

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        wcyc(6);
        `CHK({srq_oe, d_nrfd_oe}, 2'h2)
        rst_n_in = 1'b1;
        wcyc(3);
        `CHK({talker, listener, remote}, 3'h0)
        t_listen();
        t_panel();
        t_talk();
        t_poll();
        t_clear();
        close_out();
    end
    // tests take a few hundred cycles
    initial begin
        repeat (30000) @(posedge clock_in);
        fail_count++;
        close_out();
    end
endmodule : tb_gpib_device_interface
